// ---- hdl/psc_pkg.sv ----
`default_nettype none
package psc_pkg;

  // raw strap vector layout, one bit per strap pin
  localparam int RAW_W      = 16;
  localparam int POS_ARB    = 0;
  localparam int POS_BS_LO  = 1;
  localparam int BS_W       = 5;
  localparam int POS_CS_POL = 6;
  localparam int POS_ENDIAN = 7;
  localparam int POS_BOOT   = 8;
  localparam int POS_ND_LO  = 9;
  localparam int ND_W       = 5;
  localparam int POS_FS_LO  = 14;
  localparam int FS_W       = 2;

  // positions inside the 5-bit strap group
  localparam int BS_WE_STYLE  = 0;
  localparam int BS_PCI_MODE  = 1;
  localparam int BS_READ_MODE = 2;
  localparam int BS_WIDTH_LO  = 3;

  // all pins at their internal pull-up level
  localparam logic [RAW_W-1:0] RAW_RST = 16'hffff;

  localparam int MULT_W = 6;
  localparam int DIV_W  = 4;

  typedef enum logic [1:0] {
    PSC_CS1_W16 = 2'h0,
    PSC_CS1_W8  = 2'h1,
    PSC_CS1_RSV = 2'h2,
    PSC_CS1_W32 = 2'h3
  } psc_cs1_width_t;

  typedef enum logic [1:0] {
    PSC_ST_WAIT = 2'h0,
    PSC_ST_HOLD = 2'h1,
    PSC_ST_RUN  = 2'h2
  } psc_state_t;

  // output values while reset is applied (pull-up decode)
  localparam logic                 ARB_INT_RST    = 1'b1;
  localparam logic                 BYTE_LANE_RST  = 1'b0;
  localparam psc_cs1_width_t       CS1_WIDTH_RST  = PSC_CS1_W32;
  localparam logic                 CMD_DLY_RST    = 1'b0;
  localparam logic                 PCI_MODE_RST   = 1'b1;
  localparam logic                 CS_LOW_RST     = 1'b1;
  localparam logic                 LITTLE_END_RST = 1'b1;
  localparam logic                 FLASH_BOOT_RST = 1'b1;
  localparam logic [ND_W-1:0]      ND_RST         = 5'h1f;
  localparam logic [MULT_W-1:0]    MULT_RST       = 6'h20;
  localparam logic [FS_W-1:0]      FS_RST         = 2'h1;
  localparam logic [DIV_W-1:0]     DIV_RST        = 4'h2;

endpackage : psc_pkg
`default_nettype wire

// ---- hdl/psc_strap_sampler.sv ----
`default_nettype none
module psc_strap_sampler (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic [psc_pkg::RAW_W-1:0] pins,
  output var  logic [psc_pkg::RAW_W-1:0] raw_q,
  output var  logic                      taken_q,
  output var  logic                      done_q
);
  import psc_pkg::*;

  // one sample on the first edge after reset release
  always_ff @(posedge mclk) begin
    if (rst) begin
      raw_q   <= RAW_RST;
      taken_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      taken_q <= 1'b0;
      if (!done_q) begin
        raw_q   <= pins;
        taken_q <= 1'b1;
        done_q  <= 1'b1;
      end
    end
  end

  chk_sample_once: assert property (@(posedge mclk) disable iff (rst)
    done_q |=> $stable(raw_q) && !taken_q)
    else $error("strap sample changed after capture");

endmodule : psc_strap_sampler
`default_nettype wire

// ---- hdl/psc_powerup_config.sv ----
`default_nettype none
module psc_powerup_config (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       arb_select_pin,
  input  wire logic [psc_pkg::BS_W-1:0]   boot_strap_pins,
  input  wire logic                       cs_polarity_pin,
  input  wire logic                       byte_order_pin,
  input  wire logic                       boot_status_i,
  output var  logic                       boot_status_o,
  output var  logic                       boot_status_oe_n,
  input  wire logic [psc_pkg::ND_W-1:0]   pll_mult_pins,
  input  wire logic [psc_pkg::FS_W-1:0]   pll_div_pins,
  input  wire logic                       cpu_released,
  output var  logic                       cfg_valid_q,
  output var  logic                       pci_arb_internal_q,
  output var  logic                       cs1_byte_lane_en_q,
  output var  psc_pkg::psc_cs1_width_t    cs1_width_q,
  output var  logic                       cs1_width_rsv_q,
  output var  logic                       cmd_delayed_read_q,
  output var  logic                       read_mode_rsv_q,
  output var  logic                       pci_mode_q,
  output var  logic                       cs_active_low_q,
  output var  logic                       little_endian_q,
  output var  logic                       boot_from_flash_q,
  output var  logic [psc_pkg::ND_W-1:0]   pll_multiplier_field_q,
  output var  logic [psc_pkg::MULT_W-1:0] pll_multiplier_q,
  output var  logic [psc_pkg::FS_W-1:0]   pll_output_divider_field_q,
  output var  logic [psc_pkg::DIV_W-1:0]  pll_divide_by_q,
  output var  logic                       cpu_run_q
);
  import psc_pkg::*;

  logic [RAW_W-1:0] pins;
  logic [RAW_W-1:0] raw;
  logic             taken;
  logic [BS_W-1:0]  bs;
  logic [ND_W-1:0]  nd;
  logic [FS_W-1:0]  fs_pins;
  logic [FS_W-1:0]  fs_code;
  psc_state_t       state_q;
  psc_state_t       state_d;
  logic             serial_release;

  assign pins = {pll_div_pins, pll_mult_pins, boot_status_i, byte_order_pin,
                 cs_polarity_pin, boot_strap_pins, arb_select_pin};

  psc_strap_sampler u_sampler (
    .mclk    (mclk),
    .rst     (rst),
    .pins    (pins),
    .raw_q   (raw),
    .taken_q (taken),
    .done_q  ()
  );

  assign bs      = raw[POS_BS_LO +: BS_W];
  assign nd      = raw[POS_ND_LO +: ND_W];
  assign fs_pins = raw[POS_FS_LO +: FS_W];
  // pin pair 10,11,00,01 maps to code 00,01,10,11
  assign fs_code = {~fs_pins[1], fs_pins[0]};

  // decoded configuration, loaded once from the captured vector
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_valid_q                <= 1'b0;
      pci_arb_internal_q         <= ARB_INT_RST;
      cs1_byte_lane_en_q         <= BYTE_LANE_RST;
      cs1_width_q                <= CS1_WIDTH_RST;
      cs1_width_rsv_q            <= 1'b0;
      cmd_delayed_read_q         <= CMD_DLY_RST;
      read_mode_rsv_q            <= 1'b0;
      pci_mode_q                 <= PCI_MODE_RST;
      cs_active_low_q            <= CS_LOW_RST;
      little_endian_q            <= LITTLE_END_RST;
      boot_from_flash_q          <= FLASH_BOOT_RST;
      pll_multiplier_field_q     <= ND_RST;
      pll_multiplier_q           <= MULT_RST;
      pll_output_divider_field_q <= FS_RST;
      pll_divide_by_q            <= DIV_RST;
    end else if (taken) begin
      cfg_valid_q                <= 1'b1;
      pci_arb_internal_q         <= raw[POS_ARB];
      cs1_byte_lane_en_q         <= ~bs[BS_WE_STYLE];
      cs1_width_q                <= psc_cs1_width_t'(bs[BS_WIDTH_LO +: 2]);
      cs1_width_rsv_q            <= (bs[BS_WIDTH_LO +: 2] == PSC_CS1_RSV);
      cmd_delayed_read_q         <= ~bs[BS_READ_MODE];
      // high level is an unsupported board setting, flagged
      read_mode_rsv_q            <= bs[BS_READ_MODE];
      pci_mode_q                 <= bs[BS_PCI_MODE];
      cs_active_low_q            <= raw[POS_CS_POL];
      little_endian_q            <= raw[POS_ENDIAN];
      boot_from_flash_q          <= raw[POS_BOOT];
      pll_multiplier_field_q     <= nd;
      pll_multiplier_q           <= {1'b0, nd} + 6'h01;
      pll_output_divider_field_q <= fs_code;
      pll_divide_by_q            <= 4'h1 << fs_code;
    end
  end

  // boot sequencing: wait for capture, hold cpu, then run
  assign serial_release = cpu_released && !boot_from_flash_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PSC_ST_WAIT: begin
        if (taken) begin
          state_d = PSC_ST_HOLD;
        end
      end
      PSC_ST_HOLD: begin
        if (cpu_released) begin
          state_d = PSC_ST_RUN;
        end
      end
      PSC_ST_RUN: begin
        state_d = PSC_ST_RUN;
      end
      default: begin
        state_d = PSC_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= PSC_ST_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_run_q <= 1'b0;
    end else if (state_q == PSC_ST_HOLD && cpu_released) begin
      cpu_run_q <= 1'b1;
    end
  end

  // boot-status pin: input until a serial boot finishes, then driven high
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_status_o    <= 1'b1;
      boot_status_oe_n <= 1'b1;
    end else begin
      boot_status_o <= 1'b1;
      if (state_q == PSC_ST_HOLD && serial_release) begin
        boot_status_oe_n <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_valid_after_take: assert property (taken |=> cfg_valid_q ##1 cfg_valid_q)
    else $error("configuration not valid after capture");

  chk_valid_only_taken: assert property ($rose(cfg_valid_q) |-> $past(taken))
    else $error("configuration valid without a capture");

  chk_arb_source: assert property (cfg_valid_q |-> pci_arb_internal_q == raw[POS_ARB])
    else $error("arbiter source does not follow strap");

  chk_write_style: assert property (cfg_valid_q |-> cs1_byte_lane_en_q != bs[BS_WE_STYLE])
    else $error("chip select 1 write style wrong");

  chk_cs1_width: assert property (cfg_valid_q |->
    (cs1_width_q == PSC_CS1_W16) == (bs[4:3] == 2'h0) &&
    (cs1_width_q == PSC_CS1_W8) == (bs[4:3] == 2'h1) &&
    (cs1_width_q == PSC_CS1_W32) == (bs[4:3] == 2'h3))
    else $error("chip select 1 width wrong");

  chk_read_mode: assert property (cfg_valid_q |->
    cmd_delayed_read_q != read_mode_rsv_q && read_mode_rsv_q == bs[BS_READ_MODE])
    else $error("read mode decode wrong");

  chk_port_mode: assert property (cfg_valid_q |-> pci_mode_q == bs[BS_PCI_MODE])
    else $error("expansion port mode wrong");

  chk_polarity_order: assert property (cfg_valid_q |->
    cs_active_low_q == raw[POS_CS_POL] && little_endian_q == raw[POS_ENDIAN])
    else $error("polarity or byte order wrong");

  chk_boot_source: assert property (cfg_valid_q |-> boot_from_flash_q == raw[POS_BOOT])
    else $error("boot source wrong");

  chk_pll_multiplier: assert property (cfg_valid_q |->
    pll_multiplier_q == {1'b0, pll_multiplier_field_q} + 6'h01 && pll_multiplier_field_q == nd)
    else $error("multiplier is not field plus one");

  chk_pll_divider: assert property (cfg_valid_q |->
    (fs_pins == 2'h2 -> pll_divide_by_q == 4'h1) && (fs_pins == 2'h3 -> pll_divide_by_q == 4'h2) &&
    (fs_pins == 2'h0 -> pll_divide_by_q == 4'h4) && (fs_pins == 2'h1 -> pll_divide_by_q == 4'h8))
    else $error("output divider decode wrong");

  chk_config_frozen: assert property (cfg_valid_q ##1 cfg_valid_q |->
    $stable(pll_multiplier_q) && $stable(pll_divide_by_q) && $stable(boot_from_flash_q) &&
    $stable(little_endian_q) && $stable(cs1_width_q))
    else $error("configuration changed after capture");

  chk_pin_drive: assert property (state_q == PSC_ST_HOLD && serial_release |=>
    !boot_status_oe_n && boot_status_o && cpu_run_q)
    else $error("boot-status pin not driven after serial boot");

  chk_pin_quiet: assert property (!cpu_run_q || boot_from_flash_q |-> boot_status_oe_n)
    else $error("boot-status pin driven too early");

  chk_reset_defaults: assert property (disable iff (1'b0) rst |=>
    !cfg_valid_q &&
    pci_arb_internal_q == ARB_INT_RST &&
    cs1_byte_lane_en_q == BYTE_LANE_RST &&
    cs1_width_q == CS1_WIDTH_RST &&
    !cs1_width_rsv_q &&
    cmd_delayed_read_q == CMD_DLY_RST &&
    !read_mode_rsv_q &&
    pci_mode_q == PCI_MODE_RST &&
    cs_active_low_q == CS_LOW_RST &&
    little_endian_q == LITTLE_END_RST &&
    boot_from_flash_q == FLASH_BOOT_RST &&
    pll_multiplier_field_q == ND_RST &&
    pll_multiplier_q == MULT_RST &&
    pll_output_divider_field_q == FS_RST &&
    pll_divide_by_q == DIV_RST &&
    boot_status_o &&
    boot_status_oe_n &&
    !cpu_run_q)
    else $error("outputs not at pull-up defaults during reset");

  chk_taken_single: assert property (taken |=> !taken && state_q == PSC_ST_HOLD)
    else $error("strap vector taken more than once");

  chk_valid_sticky: assert property (cfg_valid_q |=> cfg_valid_q)
    else $error("configuration valid dropped without reset");

  chk_wait_quiet: assert property (state_q == PSC_ST_WAIT |-> !cfg_valid_q && !cpu_run_q)
    else $error("configuration or cpu run before capture");

  chk_hold_cpu: assert property (state_q == PSC_ST_HOLD && !cpu_released |=>
    state_q == PSC_ST_HOLD && !cpu_run_q && boot_status_oe_n)
    else $error("cpu run or pin drive without release");

  chk_release_run: assert property (state_q == PSC_ST_HOLD && cpu_released |=> cpu_run_q)
    else $error("cpu run not set after release");

  chk_run_sticky: assert property (cpu_run_q |=> cpu_run_q && state_q == PSC_ST_RUN)
    else $error("cpu run dropped without reset");

  chk_drive_sticky: assert property (!boot_status_oe_n |=> !boot_status_oe_n && boot_status_o)
    else $error("boot-status drive dropped without reset");

  chk_drive_serial: assert property (!boot_status_oe_n |-> !boot_from_flash_q && cfg_valid_q)
    else $error("boot-status pin driven on a flash boot");

  chk_width_flag: assert property (cfg_valid_q |-> cs1_width_rsv_q == (bs[4:3] == 2'h2))
    else $error("reserved width flag wrong");

  chk_mult_range: assert property (cfg_valid_q |-> pll_multiplier_q != 6'h00 && pll_multiplier_q <= 6'h20)
    else $error("multiplier out of range");

  chk_div_field: assert property (cfg_valid_q |->
    (fs_pins == 2'h2 -> pll_output_divider_field_q == 2'h0) &&
    (fs_pins == 2'h3 -> pll_output_divider_field_q == 2'h1) &&
    (fs_pins == 2'h0 -> pll_output_divider_field_q == 2'h2) &&
    (fs_pins == 2'h1 -> pll_output_divider_field_q == 2'h3))
    else $error("output divider field wrong");

  chk_flags_frozen: assert property (cfg_valid_q ##1 cfg_valid_q |->
    $stable(pci_arb_internal_q) && $stable(cs1_byte_lane_en_q) && $stable(cs1_width_rsv_q) &&
    $stable(cmd_delayed_read_q) && $stable(read_mode_rsv_q) && $stable(pci_mode_q) &&
    $stable(cs_active_low_q) && $stable(pll_multiplier_field_q) && $stable(pll_output_divider_field_q))
    else $error("configuration flags changed after capture");

  chk_state_legal: assert property (state_q inside {PSC_ST_WAIT, PSC_ST_HOLD, PSC_ST_RUN})
    else $error("sequencer in an illegal state");

  cov_serial_boot: cover property (cfg_valid_q && !boot_from_flash_q ##[1:20] !boot_status_oe_n);
  cov_flash_boot: cover property (cfg_valid_q && boot_from_flash_q ##[1:20] cpu_run_q);
  cov_width_rsv: cover property (cfg_valid_q && cs1_width_rsv_q);
  cov_max_mult: cover property (cfg_valid_q && pll_multiplier_q == 6'h20 && pll_divide_by_q == 4'h8);
  cov_pins_wander: cover property (cfg_valid_q && pll_mult_pins != pll_multiplier_field_q);

endmodule : psc_powerup_config
`default_nettype wire

// ---- test/psc_strap_board.sv ----
`default_nettype none
module psc_strap_board (
  input  wire logic [psc_pkg::RAW_W-1:0] strap_cfg,
  input  wire logic                      boot_status_o,
  input  wire logic                      boot_status_oe_n,
  output wire logic                      arb_select_pin,
  output wire logic [psc_pkg::BS_W-1:0]  boot_strap_pins,
  output wire logic                      cs_polarity_pin,
  output wire logic                      byte_order_pin,
  output wire logic                      boot_status_i,
  output wire logic [psc_pkg::ND_W-1:0]  pll_mult_pins,
  output wire logic [psc_pkg::FS_W-1:0]  pll_div_pins,
  output wire logic                      reserved_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  // strap_cfg bit 1 = pull-up only, 0 = external pull-down fitted
  assign arb_select_pin  = strap_cfg[POS_ARB];
  assign boot_strap_pins = strap_cfg[POS_BS_LO +: BS_W];
  assign cs_polarity_pin = strap_cfg[POS_CS_POL];
  assign byte_order_pin  = strap_cfg[POS_ENDIAN];
  assign pll_mult_pins   = strap_cfg[POS_ND_LO +: ND_W];
  assign pll_div_pins    = strap_cfg[POS_FS_LO +: FS_W];
  // device drive wins over the resistor once enabled
  assign boot_status_i   = boot_status_oe_n ? strap_cfg[POS_BOOT] : boot_status_o;
  // reserved gpio pull-down switched in only once boot-status reads high
  assign reserved_pin    = ~boot_status_i;
endmodule : psc_strap_board
`default_nettype wire

// ---- test/powerup_config_capture_tb.sv ----
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module powerup_config_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic mclk, rst, cpu_released, arb, csp, byo, bsi, bso, oe_n, valid, arb_q, lane_q, wrsv_q, cmd_q;
  logic rrsv_q, pci_q, csl_q, le_q, flash_q, run_q, reserved;
  logic [RAW_W-1:0] strap_cfg;
  logic [BS_W-1:0]  bsp;
  logic [ND_W-1:0]  ndp, nd_q;
  logic [FS_W-1:0]  fsp, fs_q;
  logic [MULT_W-1:0] mult_q;
  logic [DIV_W-1:0]  div_q;
  psc_cs1_width_t    width_q;
  int n_mismatch, total_checks;
  psc_strap_board board_u (.strap_cfg(strap_cfg), .boot_status_o(bso), .boot_status_oe_n(oe_n),
    .arb_select_pin(arb), .boot_strap_pins(bsp), .cs_polarity_pin(csp), .byte_order_pin(byo),
    .boot_status_i(bsi), .pll_mult_pins(ndp), .pll_div_pins(fsp), .reserved_pin(reserved));
  psc_powerup_config dut_u (.mclk(mclk), .rst(rst), .arb_select_pin(arb), .boot_strap_pins(bsp),
    .cs_polarity_pin(csp), .byte_order_pin(byo), .boot_status_i(bsi), .boot_status_o(bso),
    .boot_status_oe_n(oe_n), .pll_mult_pins(ndp), .pll_div_pins(fsp), .cpu_released(cpu_released),
    .cfg_valid_q(valid), .pci_arb_internal_q(arb_q), .cs1_byte_lane_en_q(lane_q), .cs1_width_q(width_q),
    .cs1_width_rsv_q(wrsv_q), .cmd_delayed_read_q(cmd_q), .read_mode_rsv_q(rrsv_q), .pci_mode_q(pci_q),
    .cs_active_low_q(csl_q), .little_endian_q(le_q), .boot_from_flash_q(flash_q),
    .pll_multiplier_field_q(nd_q), .pll_multiplier_q(mult_q), .pll_output_divider_field_q(fs_q),
    .pll_divide_by_q(div_q), .cpu_run_q(run_q));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic check_cfg(input logic [RAW_W-1:0] v);
    logic [BS_W-1:0] bs;
    logic [FS_W-1:0] fp;
    logic [FS_W-1:0] code;
    logic [DIV_W-1:0] dv;
    bs = v[POS_BS_LO +: BS_W];
    fp = v[POS_FS_LO +: FS_W];
    // divider table: pins 10,11,00,01 give codes 0..3 and divide by 1,2,4,8
    code = (fp == 2'h2) ? 2'h0 : (fp == 2'h3) ? 2'h1 : (fp == 2'h0) ? 2'h2 : 2'h3;
    dv = (fp == 2'h2) ? 4'h1 : (fp == 2'h3) ? 4'h2 : (fp == 2'h0) ? 4'h4 : 4'h8;
    `CHK(valid, 1'b1)
    `CHK(arb_q, v[POS_ARB])
    `CHK(lane_q, ~bs[0])
    `CHK(width_q, bs[4:3])
    `CHK(wrsv_q, (bs[4:3] == 2'h2))
    `CHK(cmd_q, ~bs[2])
    `CHK(rrsv_q, bs[2])
    `CHK(pci_q, bs[1])
    `CHK(csl_q, v[POS_CS_POL])
    `CHK(le_q, v[POS_ENDIAN])
    `CHK(flash_q, v[POS_BOOT])
    `CHK(nd_q, v[POS_ND_LO +: ND_W])
    `CHK(mult_q, {1'b0, v[POS_ND_LO +: ND_W]} + 6'h01)
    `CHK(fs_q, code)
    `CHK(div_q, dv)
  endtask : check_cfg
  task automatic run_case(input logic [RAW_W-1:0] v);
    int i;
    @(posedge mclk);
    rst <= 1'b1;
    cpu_released <= 1'b0;
    strap_cfg <= v;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK(valid, 1'b0)
    `CHK(oe_n, 1'b1)
    @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 8 && valid !== 1'b1; i++) @(negedge mclk);
    if (valid !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    check_cfg(v);
    // pins wander after capture, captured values must not
    @(posedge mclk);
    strap_cfg <= ~v;
    repeat (3) @(negedge mclk);
    check_cfg(v);
    `CHK(oe_n, 1'b1)
    `CHK(run_q, 1'b0)
    `CHK(reserved | bsi, 1'b1)
    @(posedge mclk);
    cpu_released <= 1'b1;
    for (i = 0; i < 8 && run_q !== 1'b1; i++) @(negedge mclk);
    if (run_q !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    repeat (2) @(negedge mclk);
    `CHK(oe_n, v[POS_BOOT])
    `CHK(bso, 1'b1)
    `CHK(run_q, 1'b1)
    `CHK(reserved | bsi, 1'b1)
    if (v[POS_BOOT] == 1'b0) `CHK(bsi, 1'b1)
  endtask : run_case
  initial begin
    logic [RAW_W-1:0] cases [6];
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    cpu_released = 1'b0;
    strap_cfg = RAW_RST;
    cases = '{16'hffff, 16'h0000, 16'h4a55, 16'h8b2a, 16'hc1c6, 16'h7e00};
    repeat (2) @(posedge mclk);
    foreach (cases[k]) run_case(cases[k]);
    final_report();
  end
endmodule : powerup_config_capture_tb
`default_nettype wire
